// *** hw/tcc_pkg.sv ***
// Purpose: Shared constants for the three-timer configuration block.
// Assumes: Registers are 8 bits wide, one per 32-bit Avalon word.
// Notes: Register indices are the printed offsets; byte address = 4 * index.
package tcc_pkg;
	// Register indices (word addresses on the bus)
	localparam logic [7:0] IDX_MODE_CFG = 8'h89;
	localparam logic [7:0] IDX_LO0 = 8'h8A;
	localparam logic [7:0] IDX_LO1 = 8'h8B;
	localparam logic [7:0] IDX_HI0 = 8'h8C;
	localparam logic [7:0] IDX_HI1 = 8'h8D;
	localparam logic [7:0] IDX_CAP_CFG = 8'hC1;
	localparam logic [7:0] IDX_CAP1_LO = 8'hC2;
	localparam logic [7:0] IDX_CAP1_HI = 8'hC3;
	localparam logic [7:0] IDX_CAP2_LO = 8'hC4;
	localparam logic [7:0] IDX_CAP2_HI = 8'hC5;
	localparam logic [7:0] IDX_CAP3_LO = 8'hC6;
	localparam logic [7:0] IDX_CAP3_HI = 8'hC7;
	localparam logic [7:0] IDX_CTL2 = 8'hC8;
	localparam logic [7:0] IDX_CRC_LO = 8'hCA;
	localparam logic [7:0] IDX_CRC_HI = 8'hCB;
	localparam logic [7:0] IDX_LO2 = 8'hCC;
	localparam logic [7:0] IDX_HI2 = 8'hCD;

	// Values after reset
	localparam logic [7:0] RST_MODE_CFG = 8'h00;
	localparam logic [7:0] RST_CTL2 = 8'h00;
	localparam logic [7:0] RST_CAP_CFG = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [15:0] RST_CAPTURE = 16'h0000;
	localparam logic [15:0] RST_CRC = 16'h0000;

	// Mode register field positions
	localparam int SECOND_TIMER_GATING_BIT = 7;
	localparam int SRC1_BIT = 6;
	localparam int SECOND_TIMER_OPERATING_SELECT_LSB = 4;
	localparam int FIRST_TIMER_GATING_BIT = 3;
	localparam int SRC0_BIT = 2;
	localparam int FIRST_TIMER_OPERATING_SELECT_LSB = 0;

	// Third-timer control field positions
	localparam int PS_BIT = 7;
	localparam int IRQ3_EDGE_BIT = 6;
	localparam int IRQ2_EDGE_BIT = 5;
	localparam int RELOAD_LSB = 3;
	localparam int CMP_MODE_BIT = 2;
	localparam int INPUT_LSB = 0;

	// Enable register field positions
	localparam int CFG3_LSB = 6;
	localparam int CFG2_LSB = 4;
	localparam int CFG1_LSB = 2;
	localparam int CFG0_LSB = 0;

	// Operating codes of the first and second timers
	localparam logic [1:0] MODE_13BIT = 2'b00;
	localparam logic [1:0] MODE_16BIT = 2'b01;
	localparam logic [1:0] MODE_8RELOAD = 2'b10;
	localparam logic [1:0] MODE_SPLIT = 2'b11;

	// Third-timer input, reload and capture codes
	localparam logic [1:0] IN_STOP = 2'b00;
	localparam logic [1:0] IN_PRESCALED = 2'b01;
	localparam logic [1:0] IN_EDGE = 2'b10;
	localparam logic [1:0] IN_GATED = 2'b11;
	localparam logic [1:0] RELOAD_AUTO = 2'b10;
	localparam logic [1:0] RELOAD_PIN = 2'b11;
	localparam logic [1:0] CC_CAPTURE = 2'b11;
	localparam logic [1:0] CC_COMPARE = 2'b10;

	// Prescaler cycle counts
	localparam logic [4:0] DIV12_LAST = 5'h0B;
	localparam logic [4:0] DIV24_LAST = 5'h17;
endpackage

// *** hw/tcc_timers.sv ***
// Purpose: Three timer/counters with mode, control and capture registers.
// Assumes: One clock, inputs synchronous to it, Avalon-MM word addressing.
// Notes: Every register access completes with one cycle of waitrequest.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - Mode bit7 gates, bit6 sources second timer
// - Mode bit3 gates, bit2 sources first timer
// - Mode codes: 13-bit, 16-bit, 8-bit reload
// - Second timer code 11 holds its count
// - First timer code 11 splits into two
// - First timer count bytes at 0x8A, 0x8C
// - Second timer count bytes at 0x8B, 0x8D
// - Third timer count bytes at 0xCC, 0xCD
// - Control bit7 picks divide by 12 or 24
// - Control bits 6,5 pick interrupt edges
// - Control bits 4:3 pick reload behaviour
// - Control bit2 picks compare mode
// - Control bits 1:0 pick third timer input
// - Enable bits 7:6 steer third capture
// - Enable bits 5:4 steer second capture
// - Enable bits 3:2 steer first capture
// - Enable bits 1:0 steer compare/reload register
// - Reload on overflow or reload-pin fall
// - 13-bit mode keeps low byte top bits
// - Third timer input sampled, counts cycle after fall
module tcc_timers (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic timer0_run_in,
	input wire logic timer1_run_in,
	input wire logic ext_irq0_in,
	input wire logic ext_irq1_in,
	input wire logic timer0_event_in,
	input wire logic timer1_event_in,
	input wire logic third_timer_ext_input_in,
	input wire logic third_timer_reload_input_in,
	output logic timer0_overflow_out,
	output logic timer1_overflow_out,
	output logic timer2_overflow_out,
	output logic irq3_edge_select_out,
	output logic irq2_edge_select_out,
	output logic third_timer_compare_select_out,
	output logic compare_enable_out
);

	typedef struct packed {
		logic [7:0] mode_cfg;
		logic [7:0] lo0;
		logic [7:0] hi0;
		logic [7:0] lo1;
		logic [7:0] hi1;
		logic [7:0] t2ctl;
		logic [7:0] lo2;
		logic [7:0] hi2;
		logic [7:0] cap_cfg;
		logic [15:0] cc1;
		logic [15:0] cc2;
		logic [15:0] cc3;
		logic [15:0] crc;
		logic [4:0] pscnt;
		logic ev0_prev;
		logic ev1_prev;
		logic ext2_prev;
		logic ext2_fall;
		logic rl_prev;
		logic ack;
		logic [7:0] rdata;
		logic ovf0;
		logic ovf1;
		logic ovf2;
	} tcc_state_type;

	tcc_state_type r;
	tcc_state_type next_r;

	// Falling edge between the previous and present samples
	function automatic logic fall(input logic prev, input logic cur);
		fall = prev & ~cur;
	endfunction

	// One step of the first or second timer; returns {ovf, th, tl}
	function automatic logic [16:0] step01(input logic [1:0] mode,
		input logic [7:0] tl, input logic [7:0] th, input logic inc);
		logic [7:0] ntl;
		logic [7:0] nth;
		logic ovf;
		ntl = tl;
		nth = th;
		ovf = 1'b0;
		if (inc) begin
			unique case (mode)
				tcc_pkg::MODE_13BIT: begin
					// Top three low bits are left as they are
					ntl[4:0] = tl[4:0] + 5'h01;
					if (tl[4:0] == 5'h1F) begin
						nth = th + 8'h01;
						ovf = (th == 8'hFF);
					end
				end
				tcc_pkg::MODE_16BIT: begin
					ntl = tl + 8'h01;
					if (tl == 8'hFF) begin
						nth = th + 8'h01;
						ovf = (th == 8'hFF);
					end
				end
				tcc_pkg::MODE_8RELOAD: begin
					if (tl == 8'hFF) begin
						ntl = th;
						ovf = 1'b1;
					end else begin
						ntl = tl + 8'h01;
					end
				end
				tcc_pkg::MODE_SPLIT: begin
					// Split or held operation is handled by the caller
					ntl = tl;
				end
			endcase
		end
		step01 = {ovf, nth, ntl};
	endfunction

	logic [1:0] op0;
	logic [1:0] op1;
	logic tick12;
	logic tick24;
	logic ps_tick;
	logic req;
	logic wr_ok;
	logic [7:0] wdata;
	logic [15:0] cnt2_now;

	assign op0 = r.mode_cfg[tcc_pkg::FIRST_TIMER_OPERATING_SELECT_LSB +: 2];
	assign op1 = r.mode_cfg[tcc_pkg::SECOND_TIMER_OPERATING_SELECT_LSB +: 2];
	assign req = avs_read_in | avs_write_in;
	// Byte lane 0 carries the register; other lanes are ignored
	assign wr_ok = avs_write_in & r.ack & avs_byteenable_in[0];
	assign wdata = avs_writedata_in[7:0];
	assign cnt2_now = {r.hi2, r.lo2};

	// One prescaler feeds all timers: every 12 cycles, or every 12 or 24 for the third timer
	assign tick12 = (r.pscnt == tcc_pkg::DIV12_LAST) ||
		(r.pscnt == tcc_pkg::DIV24_LAST);
	assign tick24 = (r.pscnt == tcc_pkg::DIV24_LAST);
	assign ps_tick = r.t2ctl[tcc_pkg::PS_BIT] ? tick24 : tick12;

	// Waitrequest drops in the cycle after the request is seen
	assign avs_waitrequest_out = req & ~r.ack;
	assign avs_readdata_out = {24'h000000, r.rdata};
	assign timer0_overflow_out = r.ovf0;
	assign timer1_overflow_out = r.ovf1;
	assign timer2_overflow_out = r.ovf2;
	assign irq3_edge_select_out = r.t2ctl[tcc_pkg::IRQ3_EDGE_BIT];
	assign irq2_edge_select_out = r.t2ctl[tcc_pkg::IRQ2_EDGE_BIT];
	assign third_timer_compare_select_out =
		r.t2ctl[tcc_pkg::CMP_MODE_BIT];
	assign compare_enable_out =
		(r.cap_cfg[tcc_pkg::CFG0_LSB +: 2] == tcc_pkg::CC_COMPARE);

	// Next state: counting first, then software writes take precedence
	always_comb begin
		logic en0;
		logic en1;
		logic inc0;
		logic inc1;
		logic inc_h0;
		logic inc2;
		logic rl_fall;
		logic [16:0] s0;
		logic [16:0] s1;
		logic [16:0] sum2;
		logic [7:0] rd;
		next_r = r;
		en0 = 1'b0;
		en1 = 1'b0;
		inc0 = 1'b0;
		inc1 = 1'b0;
		inc_h0 = 1'b0;
		inc2 = 1'b0;
		rl_fall = 1'b0;
		s0 = 17'h00000;
		s1 = 17'h00000;
		sum2 = 17'h00000;
		rd = 8'h00;

		// Prescaler wraps after 24 cycles
		if (r.pscnt == tcc_pkg::DIV24_LAST) begin
			next_r.pscnt = 5'h00;
		end else begin
			next_r.pscnt = r.pscnt + 5'h01;
		end

		// Sample the event pins every cycle for edge detection
		next_r.ev0_prev = timer0_event_in;
		next_r.ev1_prev = timer1_event_in;
		next_r.ext2_prev = third_timer_ext_input_in;
		next_r.rl_prev = third_timer_reload_input_in;

		// Gate bit lets the external interrupt pin hold the timer
		en0 = timer0_run_in &
			(~r.mode_cfg[tcc_pkg::FIRST_TIMER_GATING_BIT] | ext_irq0_in);
		en1 = timer1_run_in &
			(~r.mode_cfg[tcc_pkg::SECOND_TIMER_GATING_BIT] | ext_irq1_in);
		// Source bit: 1 counts pin falls, 0 counts prescaled cycles
		inc0 = en0 & (r.mode_cfg[tcc_pkg::SRC0_BIT] ?
			fall(r.ev0_prev, timer0_event_in) : tick12);
		inc1 = en1 & (r.mode_cfg[tcc_pkg::SRC1_BIT] ?
			fall(r.ev1_prev, timer1_event_in) : tick12);

		// First timer
		s0 = step01(op0, r.lo0, r.hi0, inc0);
		next_r.ovf0 = 1'b0;
		next_r.ovf1 = 1'b0;
		if (op0 == tcc_pkg::MODE_SPLIT) begin
			// Low byte is a full 8-bit counter on the first controls,
			// high byte is a plain timer run by the second run input
			inc_h0 = timer1_run_in & tick12;
			if (inc0) begin
				next_r.lo0 = r.lo0 + 8'h01;
				next_r.ovf0 = (r.lo0 == 8'hFF);
			end
			if (inc_h0) begin
				next_r.hi0 = r.hi0 + 8'h01;
				next_r.ovf1 = (r.hi0 == 8'hFF);
			end
		end else begin
			next_r.lo0 = s0[7:0];
			next_r.hi0 = s0[15:8];
			next_r.ovf0 = s0[16];
		end

		// Second timer; code 11 freezes it where it stands
		if (op1 != tcc_pkg::MODE_SPLIT) begin
			s1 = step01(op1, r.lo1, r.hi1, inc1);
			next_r.lo1 = s1[7:0];
			next_r.hi1 = s1[15:8];
			// Split first timer owns this overflow flag
			if (op0 != tcc_pkg::MODE_SPLIT) begin
				next_r.ovf1 = s1[16];
			end
		end

		// Third timer input: edge flag delays the count by a cycle
		next_r.ext2_fall = 1'b0;
		unique case (r.t2ctl[tcc_pkg::INPUT_LSB +: 2])
			tcc_pkg::IN_STOP: inc2 = 1'b0;
			tcc_pkg::IN_PRESCALED: inc2 = ps_tick;
			tcc_pkg::IN_EDGE: begin
				next_r.ext2_fall = fall(r.ext2_prev,
					third_timer_ext_input_in);
				inc2 = r.ext2_fall;
			end
			tcc_pkg::IN_GATED: begin
				inc2 = ps_tick & third_timer_ext_input_in;
			end
		endcase

		sum2 = {1'b0, cnt2_now} + 17'h00001;
		rl_fall = fall(r.rl_prev, third_timer_reload_input_in);
		next_r.ovf2 = inc2 & sum2[16];
		unique case (r.t2ctl[tcc_pkg::RELOAD_LSB +: 2])
			tcc_pkg::RELOAD_AUTO: begin
				// Overflow loads the compare/reload value
				if (inc2 && sum2[16]) begin
					{next_r.hi2, next_r.lo2} = r.crc;
				end else if (inc2) begin
					{next_r.hi2, next_r.lo2} = sum2[15:0];
				end
			end
			tcc_pkg::RELOAD_PIN: begin
				// Reload pin fall wins over a count in the same cycle
				if (rl_fall) begin
					{next_r.hi2, next_r.lo2} = r.crc;
				end else if (inc2) begin
					{next_r.hi2, next_r.lo2} = sum2[15:0];
				end
			end
			default: begin
				// Codes 0X: plain wrap, no reload
				if (inc2) begin
					{next_r.hi2, next_r.lo2} = sum2[15:0];
				end
			end
		endcase

		// Software writes land on the edge where waitrequest is low
		if (wr_ok) begin
			unique case (avs_address_in)
				tcc_pkg::IDX_MODE_CFG: next_r.mode_cfg = wdata;
				tcc_pkg::IDX_LO0: next_r.lo0 = wdata;
				tcc_pkg::IDX_HI0: next_r.hi0 = wdata;
				tcc_pkg::IDX_LO1: next_r.lo1 = wdata;
				tcc_pkg::IDX_HI1: next_r.hi1 = wdata;
				tcc_pkg::IDX_CTL2: next_r.t2ctl = wdata;
				tcc_pkg::IDX_LO2: next_r.lo2 = wdata;
				tcc_pkg::IDX_HI2: next_r.hi2 = wdata;
				tcc_pkg::IDX_CAP_CFG: next_r.cap_cfg = wdata;
				tcc_pkg::IDX_CAP1_LO: begin
					// Capture mode swaps the stored byte for the count
					if (r.cap_cfg[tcc_pkg::CFG1_LSB +: 2] ==
						tcc_pkg::CC_CAPTURE) begin
						next_r.cc1 = cnt2_now;
					end else begin
						next_r.cc1[7:0] = wdata;
					end
				end
				tcc_pkg::IDX_CAP1_HI: next_r.cc1[15:8] = wdata;
				tcc_pkg::IDX_CAP2_LO: begin
					if (r.cap_cfg[tcc_pkg::CFG2_LSB +: 2] ==
						tcc_pkg::CC_CAPTURE) begin
						next_r.cc2 = cnt2_now;
					end else begin
						next_r.cc2[7:0] = wdata;
					end
				end
				tcc_pkg::IDX_CAP2_HI: next_r.cc2[15:8] = wdata;
				tcc_pkg::IDX_CAP3_LO: begin
					if (r.cap_cfg[tcc_pkg::CFG3_LSB +: 2] ==
						tcc_pkg::CC_CAPTURE) begin
						next_r.cc3 = cnt2_now;
					end else begin
						next_r.cc3[7:0] = wdata;
					end
				end
				tcc_pkg::IDX_CAP3_HI: next_r.cc3[15:8] = wdata;
				tcc_pkg::IDX_CRC_LO: begin
					if (r.cap_cfg[tcc_pkg::CFG0_LSB +: 2] ==
						tcc_pkg::CC_CAPTURE) begin
						next_r.crc = cnt2_now;
					end else begin
						next_r.crc[7:0] = wdata;
					end
				end
				tcc_pkg::IDX_CRC_HI: next_r.crc[15:8] = wdata;
				default: next_r.ack = r.ack; // Unmapped writes ignored
			endcase
		end

		// Read mux; unmapped addresses read as zero
		unique case (avs_address_in)
			tcc_pkg::IDX_MODE_CFG: rd = r.mode_cfg;
			tcc_pkg::IDX_LO0: rd = r.lo0;
			tcc_pkg::IDX_HI0: rd = r.hi0;
			tcc_pkg::IDX_LO1: rd = r.lo1;
			tcc_pkg::IDX_HI1: rd = r.hi1;
			tcc_pkg::IDX_CTL2: rd = r.t2ctl;
			tcc_pkg::IDX_LO2: rd = r.lo2;
			tcc_pkg::IDX_HI2: rd = r.hi2;
			tcc_pkg::IDX_CAP_CFG: rd = r.cap_cfg;
			tcc_pkg::IDX_CAP1_LO: rd = r.cc1[7:0];
			tcc_pkg::IDX_CAP1_HI: rd = r.cc1[15:8];
			tcc_pkg::IDX_CAP2_LO: rd = r.cc2[7:0];
			tcc_pkg::IDX_CAP2_HI: rd = r.cc2[15:8];
			tcc_pkg::IDX_CAP3_LO: rd = r.cc3[7:0];
			tcc_pkg::IDX_CAP3_HI: rd = r.cc3[15:8];
			tcc_pkg::IDX_CRC_LO: rd = r.crc[7:0];
			tcc_pkg::IDX_CRC_HI: rd = r.crc[15:8];
			default: rd = 8'h00;
		endcase

		// Read data is latched with the answer and held until the next
		next_r.ack = req & ~r.ack;
		if (avs_read_in && !r.ack) begin
			next_r.rdata = rd;
		end
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
			r.mode_cfg <= tcc_pkg::RST_MODE_CFG;
			r.t2ctl <= tcc_pkg::RST_CTL2;
			r.cap_cfg <= tcc_pkg::RST_CAP_CFG;
			r.lo0 <= tcc_pkg::RST_COUNT;
			r.hi0 <= tcc_pkg::RST_COUNT;
			r.lo1 <= tcc_pkg::RST_COUNT;
			r.hi1 <= tcc_pkg::RST_COUNT;
			r.lo2 <= tcc_pkg::RST_COUNT;
			r.hi2 <= tcc_pkg::RST_COUNT;
			r.cc1 <= tcc_pkg::RST_CAPTURE;
			r.cc2 <= tcc_pkg::RST_CAPTURE;
			r.cc3 <= tcc_pkg::RST_CAPTURE;
			r.crc <= tcc_pkg::RST_CRC;
		end else if (clk_en_in) begin
			r <= next_r;
		end
	end

endmodule // tcc_timers

// *** tb/tcc_timers_sva.sv ***
// Purpose: Port checker for the three-timer block.
// Assumes: A write lands at the edge where waitrequest is low.
// Notes: Shadow bytes follow accepted writes, so they match the flops.
`timescale 1ns/1ps
module tcc_timers_sva (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic timer1_overflow_out,
	input wire logic timer2_overflow_out,
	input wire logic irq3_edge_select_out,
	input wire logic irq2_edge_select_out,
	input wire logic third_timer_compare_select_out,
	input wire logic compare_enable_out
);
	logic acc;
	logic [7:0] timer01_mode_config;
	logic [7:0] timer2_control;
	logic [7:0] compare_capture_enable;

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	// Accepted write; byteenable bit 0 gates the store
	assign acc = avs_write_in && !avs_waitrequest_out && clk_en_in &&
		avs_byteenable_in[0];

	// Shadow copies of the three control bytes
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer01_mode_config <= 8'h00;
			timer2_control <= 8'h00;
			compare_capture_enable <= 8'h00;
		end else if (acc) begin
			if (avs_address_in == 8'h89) timer01_mode_config <= avs_writedata_in[7:0];
			if (avs_address_in == 8'hC8) timer2_control <= avs_writedata_in[7:0];
			if (avs_address_in == 8'hC1) compare_capture_enable <= avs_writedata_in[7:0];
		end
	end

	chk_wait_first: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
		else $error("read accepted with no wait cycle");
	chk_wait_once: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out && clk_en_in |=> !avs_waitrequest_out)
		else $error("more than one wait cycle");
	chk_idle_nowait: assert property (!(avs_read_in || avs_write_in) |->
		!avs_waitrequest_out)
		else $error("waitrequest high while idle");
	chk_upper_zero: assert property (avs_readdata_out[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	chk_irq_edges: assert property (acc && avs_address_in == 8'hC8 |=>
		irq3_edge_select_out == $past(avs_writedata_in[6]) &&
		irq2_edge_select_out == $past(avs_writedata_in[5]))
		else $error("edge selects do not follow control write");
	chk_cmp_mode: assert property (##1 third_timer_compare_select_out ==
		timer2_control[2])
		else $error("compare mode output wrong");
	chk_cmp_enable: assert property (##1 compare_enable_out ==
		(compare_capture_enable[1:0] == 2'b10))
		else $error("compare enable output wrong");
	chk_t2_stopped: assert property ((timer2_control[1:0] == 2'b00) [*2] |->
		!timer2_overflow_out)
		else $error("stopped third timer overflowed");
	chk_t1_hold: assert property ((timer01_mode_config[5:4] == 2'b11 &&
		timer01_mode_config[1:0] != 2'b11) [*2] |-> !timer1_overflow_out)
		else $error("held second timer overflowed");
	chk_t2_pulse: assert property (timer2_overflow_out |=> !timer2_overflow_out)
		else $error("overflow pulse longer than one cycle");
endmodule // tcc_timers_sva

bind tcc_timers tcc_timers_sva i_tcc_timers_sva (.clk_sys_in, .rst_n_in,
	.clk_en_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
	.avs_waitrequest_out, .timer1_overflow_out, .timer2_overflow_out,
	.irq3_edge_select_out, .irq2_edge_select_out,
	.third_timer_compare_select_out, .compare_enable_out);

// *** tb/test_tcc_timers.sv ***
// Purpose: Self-checking bench for the three-timer block.
// Assumes: One wait cycle per access; fixed seed for repeatable runs.
// Notes: Count windows span whole prescaler periods so deltas are exact.
`timescale 1ns/1ps
module test_tcc_timers;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hF;
	logic [1:0] run = 2'b00;
	logic [1:0] irq = 2'b00;
	logic [1:0] ev = 2'b00;
	logic t2in = 1'b0;
	logic t2rl = 1'b0;
	wire [31:0] rdata;
	wire [2:0] ovf;
	wire wait_r, e3, e2, cs, ce;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int i, k;
	integer seed = 32'h9FFD;
	logic [7:0] q, v0, d, r;
	logic [7:0] th_t [4] = '{8'hFF, 8'hFF, 8'h80, 8'h12};
	logic [7:0] eh_t [4] = '{8'h00, 8'h00, 8'h80, 8'h12};
	logic [7:0] el_t [4] = '{8'hE0, 8'h00, 8'h80, 8'h00};
	logic [7:0] c2_t [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h81};
	logic [7:0] x2_t [5] = '{8'h00, 8'h0A, 8'h0A, 8'h05, 8'h05};
	logic [7:0] cn_t [6] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCC, 8'hCD};
	logic [7:0] cc_t [4] = '{8'hC2, 8'hC4, 8'hC6, 8'hCA};

	tcc_timers i_tcc_timers (.clk_sys_in(clk), .rst_n_in(rst_n),
		.clk_en_in(1'b1), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
		.timer0_run_in(run[0]), .timer1_run_in(run[1]),
		.ext_irq0_in(irq[0]), .ext_irq1_in(irq[1]),
		.timer0_event_in(ev[0]), .timer1_event_in(ev[1]),
		.third_timer_ext_input_in(t2in), .third_timer_reload_input_in(t2rl),
		.timer0_overflow_out(ovf[0]), .timer1_overflow_out(ovf[1]),
		.timer2_overflow_out(ovf[2]), .irq3_edge_select_out(e3),
		.irq2_edge_select_out(e2), .third_timer_compare_select_out(cs),
		.compare_enable_out(ce));

	// 100 MHz clock
	always #5 clk = ~clk;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard, well above the roughly 1400 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One access; held until waitrequest is seen low, then one idle edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] x);
		int n;
		n = 0;
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h0, x};
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0); // Only the hang guard ends a wait
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_ovf(input int b);
		int n;
		n = 0;
		while (ovf[b] !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk("overflow", {7'h0, ovf[b]}, 8'h01);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset values, unmapped place, write with byte lane 0 off
		bus(0, 8'h89, 8'h00); chk("mode reset", q, 8'h00);
		bus(0, 8'hC1, 8'h00); chk("enable reset", q, 8'h00);
		bus(0, 8'hC8, 8'h00); chk("control reset", q, 8'h00);
		be <= 4'hE;
		bus(1, 8'h89, 8'hAA);
		be <= 4'hF;
		bus(0, 8'h89, 8'h00); chk("lane off", q, 8'h00);
		bus(1, 8'h10, 8'h77);
		bus(0, 8'h10, 8'h00); chk("unmapped", q, 8'h00);
		// Random control bytes; capture fields limited to legal codes
		for (i = 0; i < 30; i++) begin
			r = 8'($random(seed));
			{irq, ev, t2in} <= 5'($random(seed));
			k = ($random(seed) & 3) % 3;
			v0 = (k == 0) ? 8'h89 : (k == 1) ? 8'hC1 : 8'hC8;
			d = (k == 1) ? {{2{r[7]}}, {2{r[5]}}, {2{r[3]}}, r[1:0]} : r;
			bus(1, v0, d);
			bus(0, v0, 8'h00); chk("control", q, d);
			if (k == 2) chk("edges", {cs, e3, e2}, {5'h0, d[2], d[6:5]});
			if (k == 1) chk("cmp en", {7'h0, ce}, {7'h0, d[1:0] == 2'b10});
		end
		irq <= 2'b00;
		ev <= 2'b00;
		bus(1, 8'hC8, 8'h00);
		// Count bytes of all three timers, timers stopped
		for (i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			bus(1, cn_t[i], d);
			bus(0, cn_t[i], 8'h00); chk("count", q, d);
		end
		// First timer through its four modes up to overflow
		for (i = 0; i < 4; i++) begin
			bus(1, 8'h89, 8'(i));
			bus(1, 8'h8C, th_t[i]);
			bus(1, 8'h8A, 8'hFF);
			run[0] <= 1'b1;
			wait_ovf(0);
			run[0] <= 1'b0;
			bus(0, 8'h8C, 8'h00); chk("high", q, eh_t[i]);
			bus(0, 8'h8A, 8'h00); chk("low", q, el_t[i]);
		end
		// Split high byte one tick short of overflow
		bus(1, 8'h8C, 8'hFF);
		run[1] <= 1'b1;
		wait_ovf(1);
		// Second timer in code 11 keeps its value
		bus(1, 8'h89, 8'h30);
		bus(1, 8'h8B, 8'hFF);
		bus(1, 8'h8D, 8'hFF);
		repeat (60) @(posedge clk);
		bus(0, 8'h8B, 8'h00); chk("held", q, 8'hFF);
		run[1] <= 1'b0;
		// Gate blocks timing; source bit counts falling edges
		for (i = 0; i < 2; i++) begin
			run[i] <= 1'b1;
			bus(1, 8'h89, 8'(8'h09 << (4 * i)));
			bus(1, 8'(8'h8A + i), 8'h00);
			repeat (60) @(posedge clk);
			bus(0, 8'(8'h8A + i), 8'h00); chk("gated", q, 8'h00);
			bus(1, 8'h89, 8'(8'h05 << (4 * i)));
			for (k = 0; k < 7; k++) begin
				ev[i] <= 1'b1;
				repeat (2) @(posedge clk);
				ev[i] <= 1'b0;
				repeat (2) @(posedge clk);
			end
			bus(0, 8'(8'h8A + i), 8'h00); chk("events", q, 8'h07);
			run[i] <= 1'b0;
		end
		// Third timer input codes and prescaler over 120 cycles
		for (i = 0; i < 5; i++) begin
			bus(1, 8'hC8, 8'h00);
			bus(1, 8'hCC, 8'h00);
			t2in <= 1'b0;
			bus(1, 8'hC8, c2_t[i]);
			bus(0, 8'hCC, 8'h00);
			v0 = q;
			for (k = 0; k < 117; k++) begin
				t2in <= (i == 2) ? (k % 12 < 6) : (i == 3) ? (k < 60) : 1'b0;
				@(posedge clk);
			end
			bus(0, 8'hCC, 8'h00); chk("t2 delta", q - v0, x2_t[i]);
		end
		// Capture on low-byte write, then plain store when disabled
		bus(1, 8'hC8, 8'h00);
		bus(1, 8'hCC, 8'h5A);
		for (k = 0; k < 2; k++) begin
			bus(1, 8'hC1, k ? 8'h00 : 8'hFF);
			for (i = 0; i < 4; i++) begin
				bus(1, cc_t[i], 8'hA5);
				bus(0, cc_t[i], 8'h00);
				chk("capture", q, k ? 8'hA5 : 8'h5A);
			end
		end
		// Reload on reload-pin fall, then on overflow
		bus(1, 8'hCA, 8'h34);
		bus(1, 8'hCB, 8'h12);
		bus(1, 8'hC8, 8'h18);
		t2rl <= 1'b1;
		repeat (3) @(posedge clk);
		t2rl <= 1'b0;
		repeat (3) @(posedge clk);
		bus(0, 8'hCD, 8'h00); chk("pin reload", q, 8'h12);
		bus(1, 8'hCC, 8'hFF);
		bus(1, 8'hCD, 8'hFF);
		bus(1, 8'hC8, 8'h11);
		wait_ovf(2);
		bus(1, 8'hC8, 8'h00);
		bus(0, 8'hCC, 8'h00); chk("auto reload", q, 8'h34);
		end_of_test();
	end
endmodule // test_tcc_timers
